// ===== verilog/sadc_seq.sv
// Contract
// - every result is delivered as a 16-bit two's-complement word
// - a control write with a start bit set begins a conversion
// - cpu clock and flash are halted while a conversion runs
// - completion clears all three start bits
// - completion latches the result into the converted channel's data register
// - after latch and clear, the cpu clock is enabled again
// - ten registers: six config, three data, one control
// - control word selects channel and optional single-ended input
// - single-ended inputs only via channel one or two, 4-bit select
// - some single-ended sources use a fixed reduced gain
// - 3-bit resolution field picks 9 to 16 bits; fewer bits finish sooner
// - converter clock is system clock divided by 4 to 512
// - conversion takes the resolution's converter clocks at that rate
// - channels one and two pick supply, twice external, or bandgap reference
// - temperature channel always uses the bandgap reference
// - coarse offset converter follows the converter reference
// - coarse offset also applies to the temperature channel
// - 3-bit bias field; higher bias lengthens conversion
`timescale 1ns/1ps
`default_nettype none
module sadc_seq
  import sadc_pkg::*;
#(
  parameter logic [15:0] FIXED_GAIN_SE = 16'hF000
)
(
  // system
  input wire logic CLK_I,
  input wire logic RST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [5:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // cpu and flash hold
  output logic CPU_CLK_EN_O,
  output logic FLASH_HOLD_O,
  // analog front end
  output logic ANA_RUN_O,
  output logic ANA_TICK_O,
  output logic [1:0] ANA_CHAN_O,
  output logic ANA_SE_EN_O,
  output logic [3:0] ANA_SE_SEL_O,
  output logic [4:0] ANA_GAIN_O,
  output logic ANA_FIXED_GAIN_O,
  output logic [1:0] ANA_REF_O,
  output logic [1:0] ANA_CO_REF_O,
  output logic [5:0] ANA_OFFSET_O,
  output logic [2:0] ANA_BIAS_O,
  input wire logic [15:0] ANA_RESULT_I
);

  // register index of an address, IDX_NONE when unmapped
  function automatic logic [3:0] reg_index(input logic [5:0] a);
    logic [3:0] r;
    r = IDX_NONE;
    case (a)
      OFF_CFGA_1: r = 4'h0;
      OFF_CFGA_2: r = 4'h1;
      OFF_CFGA_T: r = 4'h2;
      OFF_CFGB_1: r = 4'h3;
      OFF_CFGB_2: r = 4'h4;
      OFF_CFGB_T: r = 4'h5;
      OFF_DATA_1: r = 4'h6;
      OFF_DATA_2: r = 4'h7;
      OFF_DATA_T: r = 4'h8;
      OFF_CTRL: r = 4'h9;
      default: r = IDX_NONE;
    endcase
    return r;
  endfunction

  // keep the top 9+res bits, sign stays in bit 15
  function automatic logic [15:0] res_mask(input logic [2:0] res);
    return 16'hFFFF << (3'h7 - res);
  endfunction

  // converter reference; temperature always runs on the bandgap
  function automatic logic [1:0] conv_ref(input logic [1:0] ch, input logic [1:0] sel);
    return (ch == CH_TEMP) ? REF_BANDGAP : sel;
  endfunction

  logic [15:0] cfga_reg [3];
  logic [15:0] cfgb_reg [3];
  logic [15:0] data_reg [3];
  logic [15:0] ctrl_reg;
  sadc_state_t state_reg;
  logic [1:0] ch_reg;
  logic [8:0] div_reg;
  logic [8:0] div_cnt_reg;
  logic [16:0] tick_cnt_reg;
  logic [16:0] ticks_reg;
  logic tick;
  logic [3:0] idx;
  logic wr;
  logic wr_ok;
  logic start;
  logic [1:0] start_ch;
  logic [15:0] wdata;
  logic [15:0] cur_a;
  logic [15:0] cur_b;
  logic [8:0] div_raw;
  logic [2:0] res_cur;
  logic [15:0] result;

  // apb decode; zero-wait slave, so pready is always high
  assign idx = reg_index(PADDR_I);
  assign wr = PSEL_I && PENABLE_I && PWRITE_I;
  // writes are dropped while converting so the front end stays steady
  assign wr_ok = wr && (state_reg == SADC_IDLE);
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && (idx == IDX_NONE);

  // byte lanes 0 and 1 carry the 16-bit register
  assign wdata[7:0] = PSTRB_I[0] ? PWDATA_I[7:0] : 8'h00;
  assign wdata[15:8] = PSTRB_I[1] ? PWDATA_I[15:8] : 8'h00;

  // read mux, upper half reads zero
  always_comb
  begin
    PRDATA_O = 32'h0000_0000;
    if (idx < IDX_CFGB)
      PRDATA_O[15:0] = cfga_reg[idx[1:0]];
    else if (idx < IDX_DATA)
      PRDATA_O[15:0] = cfgb_reg[2'(idx - IDX_CFGB)];
    else if (idx < IDX_CTRL)
      PRDATA_O[15:0] = data_reg[2'(idx - IDX_DATA)];
    else if (idx == IDX_CTRL)
      PRDATA_O[15:0] = ctrl_reg;
  end

  // per-channel configuration words
  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_cfg
      always_ff @(posedge CLK_I or posedge RST_I)
      begin
        if (RST_I)
        begin
          cfga_reg[g] <= REG_RESET;
          cfgb_reg[g] <= REG_RESET;
        end
        else if (wr_ok && idx == 4'(g) + IDX_CFGA)
        begin
          // strobe-less lanes keep their old value
          cfga_reg[g][7:0] <= PSTRB_I[0] ? wdata[7:0] : cfga_reg[g][7:0];
          cfga_reg[g][15:8] <= PSTRB_I[1] ? wdata[15:8] : cfga_reg[g][15:8];
        end
        else if (wr_ok && idx == 4'(g) + IDX_CFGB)
        begin
          cfgb_reg[g][7:0] <= PSTRB_I[0] ? wdata[7:0] : cfgb_reg[g][7:0];
          cfgb_reg[g][15:8] <= PSTRB_I[1] ? wdata[15:8] : cfgb_reg[g][15:8];
        end
      end
    end
  endgenerate

  // start request; several bits together resolve by priority
  assign start = wr_ok && idx == IDX_CTRL && PSTRB_I[0] && (|wdata[2:0]);
  assign start_ch = wdata[0] ? CH_ONE : (wdata[1] ? CH_TWO : CH_TEMP);

  // config of the channel being converted
  assign cur_a = cfga_reg[start ? start_ch : ch_reg];
  assign cur_b = cfgb_reg[start ? start_ch : ch_reg];
  assign res_cur = cur_a[RES_LSB +: 3];
  assign div_raw = cur_b[DIV_LSB +: 9];

  // control word; start bits live until completion
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      ctrl_reg <= REG_RESET;
    else if (state_reg == SADC_DONE)
      ctrl_reg[2:0] <= 3'h0;
    else if (wr_ok && idx == IDX_CTRL)
    begin
      ctrl_reg[7:0] <= PSTRB_I[0] ? wdata[7:0] : ctrl_reg[7:0];
      ctrl_reg[15:8] <= PSTRB_I[1] ? wdata[15:8] : ctrl_reg[15:8];
    end
  end

  // sequencer
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      state_reg <= SADC_IDLE;
    else
    begin
      case (state_reg)
        SADC_IDLE: if (start) state_reg <= SADC_CONV;
        SADC_CONV: if (tick && tick_cnt_reg == ticks_reg - 17'h1) state_reg <= SADC_DONE;
        SADC_DONE: state_reg <= SADC_IDLE;
        default: state_reg <= SADC_IDLE;
      endcase
    end
  end

  // channel, divisor and length caught at start
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ch_reg <= CH_ONE;
      div_reg <= DIV_MIN_M1;
      ticks_reg <= CONV_CLKS_BASE;
    end
    else if (start)
    begin
      ch_reg <= start_ch;
      // divisor field holds divisor-1, floored at 4
      div_reg <= (div_raw < DIV_MIN_M1) ? DIV_MIN_M1 : div_raw;
      // 9-bit needs base clocks, each extra bit doubles; higher bias stretches
      ticks_reg <= 17'((CONV_CLKS_BASE << res_cur) * (17'(cur_b[BIAS_LSB +: 3]) + 17'h1));
    end
  end

  // converter clock prescaler, runs only during a conversion
  // counting from zero at entry puts tick k at k times the divisor
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      div_cnt_reg <= 9'h000;
    else if (state_reg != SADC_CONV || tick)
      div_cnt_reg <= 9'h000;
    else
      div_cnt_reg <= div_cnt_reg + 9'h001;
  end
  assign tick = (state_reg == SADC_CONV) && (div_cnt_reg == div_reg);

  // converter clocks spent in this conversion
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      tick_cnt_reg <= 17'h0;
    else if (state_reg != SADC_CONV)
      tick_cnt_reg <= 17'h0;
    else if (tick)
      tick_cnt_reg <= tick_cnt_reg + 17'h1;
  end

  // result trimmed to resolution, always 16 bits wide
  // the analog word is taken as it stands in the done cycle
  assign result = ANA_RESULT_I & res_mask(cfga_reg[ch_reg][RES_LSB +: 3]);

  // data registers, written only by completion
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      data_reg[0] <= REG_RESET;
      data_reg[1] <= REG_RESET;
      data_reg[2] <= REG_RESET;
    end
    else if (state_reg == SADC_DONE)
      data_reg[ch_reg] <= result;
  end

  // cpu runs only while idle; done returns to idle after latching
  assign CPU_CLK_EN_O = (state_reg == SADC_IDLE);
  assign FLASH_HOLD_O = (state_reg != SADC_IDLE);

  // front-end controls follow the active channel's settings
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      ANA_RUN_O <= 1'b0;
      ANA_TICK_O <= 1'b0;
      ANA_CHAN_O <= CH_ONE;
      ANA_SE_EN_O <= 1'b0;
      ANA_SE_SEL_O <= 4'h0;
      ANA_GAIN_O <= 5'h00;
      ANA_FIXED_GAIN_O <= 1'b0;
      ANA_REF_O <= REF_SUPPLY;
      ANA_CO_REF_O <= REF_SUPPLY;
      ANA_OFFSET_O <= 6'h00;
      ANA_BIAS_O <= 3'h0;
    end
    else
    begin
      ANA_RUN_O <= (state_reg == SADC_CONV);
      ANA_TICK_O <= tick;
      ANA_CHAN_O <= ch_reg;
      // the temperature channel takes no single-ended source
      ANA_SE_EN_O <= (ch_reg != CH_TEMP) && (ctrl_reg[SE_LSB +: 4] != 4'h0);
      ANA_SE_SEL_O <= ctrl_reg[SE_LSB +: 4];
      ANA_GAIN_O <= cfga_reg[ch_reg][GAIN_LSB +: 5];
      // rail-near sources get the fixed low gain instead
      ANA_FIXED_GAIN_O <= (ch_reg != CH_TEMP) && FIXED_GAIN_SE[ctrl_reg[SE_LSB +: 4]];
      ANA_REF_O <= conv_ref(ch_reg, cfga_reg[ch_reg][REF_LSB +: 2]);
      // offset converter shares the reference to stay ratiometric
      ANA_CO_REF_O <= conv_ref(ch_reg, cfga_reg[ch_reg][REF_LSB +: 2]);
      ANA_OFFSET_O <= cfga_reg[ch_reg][OFFS_LSB +: 6];
      ANA_BIAS_O <= cfgb_reg[ch_reg][BIAS_LSB +: 3];
    end
  end

  // checks run on the system clock and sleep through reset
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_start_halts_cpu: assert property (start |=> state_reg == SADC_CONV && !CPU_CLK_EN_O)
    else $error("start did not halt cpu");
  a_flash_held: assert property (state_reg == SADC_CONV |-> FLASH_HOLD_O && !CPU_CLK_EN_O)
    else $error("flash or cpu not held");
  a_done_clears_starts: assert property (state_reg == SADC_DONE |=> ctrl_reg[2:0] == 3'h0)
    else $error("start bits not cleared");
  a_done_latches_data: assert property (state_reg == SADC_DONE |=> data_reg[$past(ch_reg)] == $past(result))
    else $error("result not latched");
  a_resume_cpu: assert property (state_reg == SADC_DONE |=> CPU_CLK_EN_O && ctrl_reg[2:0] == 3'h0)
    else $error("cpu not resumed");
  a_tick_spacing: assert property (ANA_TICK_O |=> !ANA_TICK_O [*3])
    else $error("converter clock too fast");
  a_temp_bandgap: assert property (ch_reg == CH_TEMP |=> ANA_REF_O == REF_BANDGAP)
    else $error("temperature not on bandgap");
  a_offset_ref_tied: assert property (ch_reg != CH_TEMP
    |=> ANA_CO_REF_O == $past(cfga_reg[ch_reg][REF_LSB +: 2]))
    else $error("offset reference differs");
  a_se_not_temp: assert property (ANA_SE_EN_O |-> ANA_CHAN_O != CH_TEMP)
    else $error("single-ended on temperature");
  a_unmapped_error: assert property (PSEL_I && PENABLE_I && PADDR_I > OFF_CTRL |-> PSLVERR_O)
    else $error("unmapped access not flagged");
  a_result_width: assert property (state_reg == SADC_DONE && cfga_reg[ch_reg][2:0] == 3'h0
    |=> data_reg[$past(ch_reg)][6:0] == 7'h00)
    else $error("9-bit result has low bits set");

  // sequencing and conversion length
  a_start_bits_held: assert property (state_reg == SADC_CONV |-> ctrl_reg[2:0] != 3'h0)
    else $error("start bits lost during conversion");
  a_conv_to_done: assert property (state_reg == SADC_CONV |=> state_reg != SADC_IDLE)
    else $error("conversion ended without completion");
  a_done_one_cycle: assert property (state_reg == SADC_DONE |=> state_reg == SADC_IDLE)
    else $error("completion did not return to idle");
  a_idle_holds: assert property (state_reg == SADC_IDLE && !start |=> state_reg == SADC_IDLE)
    else $error("conversion began without a start");
  a_run_follows: assert property (state_reg == SADC_CONV |=> ANA_RUN_O)
    else $error("front end not running");
  a_tick_in_run: assert property (ANA_TICK_O |-> ANA_RUN_O)
    else $error("converter clock outside conversion");
  a_tick_count_end: assert property (state_reg == SADC_DONE |-> tick_cnt_reg == ticks_reg)
    else $error("conversion length wrong");
  a_div_floor: assert property (state_reg == SADC_CONV |-> div_reg >= DIV_MIN_M1)
    else $error("divisor below four");
  a_res_mask: assert property (state_reg == SADC_DONE
    |=> (data_reg[$past(ch_reg)] & ~res_mask($past(cfga_reg[ch_reg][RES_LSB +: 3]))) == 16'h0000)
    else $error("result wider than resolution");

  // config and upper control bits frozen while the cpu is halted; data written only at completion
  a_cfg_frozen: assert property (state_reg != SADC_IDLE
    |=> $stable(cfga_reg[ch_reg]) && $stable(cfgb_reg[ch_reg]))
    else $error("config changed during conversion");
  a_ctrl_frozen: assert property (state_reg != SADC_IDLE |=> $stable(ctrl_reg[15:3]))
    else $error("control changed during conversion");
  a_data_only_done: assert property (state_reg != SADC_DONE
    |=> $stable(data_reg[0]) && $stable(data_reg[1]) && $stable(data_reg[2]))
    else $error("data register changed outside completion");
  a_fixed_not_temp: assert property (ANA_FIXED_GAIN_O |-> ANA_CHAN_O != CH_TEMP)
    else $error("fixed gain on temperature");

  // bus answers
  a_zero_wait: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
    else $error("bus access stalled");
  a_read_upper_zero: assert property (PSEL_I && PENABLE_I |-> PRDATA_O[31:16] == 16'h0000)
    else $error("upper read half not zero");

endmodule
`default_nettype wire

// ===== include/sadc_pkg.sv
package sadc_pkg;
  // apb byte offsets, one aligned word each
  localparam logic [5:0] OFF_CFGA_1 = 6'h00;
  localparam logic [5:0] OFF_CFGA_2 = 6'h04;
  localparam logic [5:0] OFF_CFGA_T = 6'h08;
  localparam logic [5:0] OFF_CFGB_1 = 6'h0C;
  localparam logic [5:0] OFF_CFGB_2 = 6'h10;
  localparam logic [5:0] OFF_CFGB_T = 6'h14;
  localparam logic [5:0] OFF_DATA_1 = 6'h18;
  localparam logic [5:0] OFF_DATA_2 = 6'h1C;
  localparam logic [5:0] OFF_DATA_T = 6'h20;
  localparam logic [5:0] OFF_CTRL = 6'h24;
  // register indices returned by the decoder
  localparam logic [3:0] IDX_CFGA = 4'h0;
  localparam logic [3:0] IDX_CFGB = 4'h3;
  localparam logic [3:0] IDX_DATA = 4'h6;
  localparam logic [3:0] IDX_CTRL = 4'h9;
  localparam logic [3:0] IDX_NONE = 4'hF;
  // channel codes
  localparam logic [1:0] CH_ONE = 2'h0;
  localparam logic [1:0] CH_TWO = 2'h1;
  localparam logic [1:0] CH_TEMP = 2'h2;
  // first config word fields
  localparam int RES_LSB = 0;
  localparam int GAIN_LSB = 3;
  localparam int REF_LSB = 8;
  localparam int OFFS_LSB = 10;
  // second config word fields
  localparam int BIAS_LSB = 0;
  localparam int DIV_LSB = 3;
  // control word fields
  localparam int SE_LSB = 3;
  // reference codes
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_EXT_X2 = 2'h1;
  localparam logic [1:0] REF_BANDGAP = 2'h2;
  // timing
  localparam logic [8:0] DIV_MIN_M1 = 9'h003;
  localparam logic [16:0] CONV_CLKS_BASE = 17'h00040;
  localparam logic [15:0] REG_RESET = 16'h0000;
  typedef enum logic [1:0]
  {
    SADC_IDLE = 2'b00,
    SADC_CONV = 2'b01,
    SADC_DONE = 2'b10
  } sadc_state_t;
endpackage

// ===== verif/sadc_afe_model.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_afe_model
(
  // system
  input wire logic clk_i,
  // converter side
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [15:0] value_i,
  output logic [15:0] result_o,
  output logic [31:0] ticks_o
);
  logic run_d = 1'b0;
  logic [15:0] junk = 16'h5A5A;
  logic [31:0] tick_cnt = 32'h0;
  // result is held one cycle past run, since the latch lands in the done cycle
  always @(posedge clk_i)
  begin
    run_d <= run_i;
    junk <= ~junk + 16'h0001;
    if (tick_i === 1'b1)
      tick_cnt <= tick_cnt + 32'h1;
  end
  // outside a conversion the word is garbage that changes every cycle
  assign result_o = (run_i === 1'b1 || run_d) ? value_i : junk;
  assign ticks_o = tick_cnt;
endmodule
`default_nettype wire

// ===== verif/test_sadc_seq.sv
`timescale 1ns/1ps
`default_nettype none
module test_sadc_seq;
  import sadc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [5:0] paddr = 6'h00;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h21D1, ticks;
  logic pready, pslverr, cpu_en, flash, run, tick, se_en, fixed;
  logic [1:0] chan, refs, co_ref;
  logic [3:0] se_sel, pstrb = 4'hF;
  logic [4:0] gain;
  logic [5:0] offs;
  logic [2:0] bias;
  logic [15:0] ana, res_val = 16'h0000;
  int err_total = 0, compares = 0, low = 0;
  logic [31:0] t0 = 32'h0;
  logic [32:0] rd_q[$];
  int cv_q[$];
  // one row per conversion: channel, resolution, bias, divisor field, reference, select
  localparam logic [1:0] CH [4] = '{CH_ONE, CH_TWO, CH_TEMP, CH_ONE};
  localparam int RS [4] = '{0, 0, 1, 7};
  localparam int BS [4] = '{0, 0, 1, 0};
  localparam int DV [4] = '{0, 511, 4, 3};
  localparam int RF [4] = '{1, 0, 0, 2};
  localparam int SE [4] = '{13, 5, 12, 0};

  sadc_seq u_sadc_seq (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .CPU_CLK_EN_O(cpu_en),
    .FLASH_HOLD_O(flash), .ANA_RUN_O(run), .ANA_TICK_O(tick), .ANA_CHAN_O(chan),
    .ANA_SE_EN_O(se_en), .ANA_SE_SEL_O(se_sel), .ANA_GAIN_O(gain), .ANA_FIXED_GAIN_O(fixed),
    .ANA_REF_O(refs), .ANA_CO_REF_O(co_ref), .ANA_OFFSET_O(offs), .ANA_BIAS_O(bias),
    .ANA_RESULT_I(ana));
  sadc_afe_model u_sadc_afe_model (.clk_i(clk), .run_i(run), .tick_i(tick),
    .value_i(res_val), .result_o(ana), .ticks_o(ticks));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task stop_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // one apb transfer; reads leave their expected word for the monitor
  task automatic apb(input logic w, input logic [5:0] a, input logic [15:0] d, input logic [32:0] e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    if (!w)
      rd_q.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run_one(input int r);
    logic [15:0] cfga, val, msk;
    logic [5:0] ca, da;
    logic [1:0] eref;
    int d, t, n;
    seed = lfsr(seed);
    val = seed[15:0];
    cfga = {seed[21:16], 2'(RF[r]), seed[26:22], 3'(RS[r])};
    ca = 6'(OFF_CFGA_1 + 4 * CH[r]);
    da = 6'(OFF_DATA_1 + 4 * CH[r]);
    d = (DV[r] < 3 ? 3 : DV[r]) + 1;
    t = (64 << RS[r]) * (BS[r] + 1);
    msk = 16'hFFFF << (7 - RS[r]);
    eref = (CH[r] == CH_TEMP) ? REF_BANDGAP : 2'(RF[r]);
    n = 0;
    res_val <= val;
    apb(1'b1, ca, cfga, 33'h0);
    apb(1'b1, 6'(OFF_CFGB_1 + 4 * CH[r]), 16'(DV[r] * 8 + BS[r]), 33'h0);
    cv_q.push_back(t * d + 1);
    cv_q.push_back(t);
    apb(1'b1, OFF_CTRL, 16'(SE[r] * 8 + (1 << CH[r])), 33'h0);
    repeat (3) @(negedge clk);
    chk("chan", CH[r], chan);
    chk("se_en", CH[r] != CH_TEMP && SE[r] != 0, se_en);
    chk("se_sel", SE[r], se_sel);
    chk("fixed", CH[r] != CH_TEMP && SE[r] >= 12, fixed);
    chk("gain", cfga[7:3], gain);
    chk("ref", eref, refs);
    chk("co_ref", eref, co_ref);
    chk("offset", cfga[15:10], offs);
    chk("bias", BS[r], bias);
    chk("flash", 1'b1, flash);
    chk("run", 1'b1, run);
    // config writes while halted must be dropped
    apb(1'b1, ca, 16'hFFFF, 33'h0);
    while (cpu_en !== 1'b1 && n < 40000)
    begin
      @(negedge clk);
      n++;
    end
    chk("cpu_en", 1'b1, cpu_en);
    chk("flash", 1'b0, flash);
    chk("run", 1'b0, run);
    apb(1'b0, ca, 16'h0000, {17'h0, cfga});
    apb(1'b0, da, 16'h0000, {17'h0, val & msk});
    apb(1'b1, da, ~val, 33'h0);
    apb(1'b0, da, 16'h0000, {17'h0, val & msk});
    apb(1'b0, OFF_CTRL, 16'h0000, 33'(SE[r] * 8));
  endtask

  // clock at 40 MHz
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // monitor: reads at the access edge, halt length and ticks when the cpu resumes
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
      chk("read", rd_q.pop_front(), {pslverr, prdata});
    if (cpu_en === 1'b0)
    begin
      if (low == 0)
        t0 = ticks;
      low++;
    end
    else
    begin
      if (low > 0 && cv_q.size() > 1)
      begin
        chk("halt", cv_q.pop_front(), low);
        chk("ticks", cv_q.pop_front(), ticks - t0);
      end
      low = 0;
    end
  end

  // watchdog sized above the four conversions
  initial
  begin
    repeat (90000) @(posedge clk);
    err_total++;
    stop_test();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++)
      apb(1'b0, 6'(4 * i), 16'h0000, 33'h0);
    apb(1'b0, 6'h28, 16'h0000, {1'b1, 32'h0});
    // a control write without lane 0 must not start anything
    pstrb <= 4'h2;
    apb(1'b1, OFF_CTRL, 16'h0001, 33'h0);
    pstrb <= 4'hF;
    apb(1'b0, OFF_CTRL, 16'h0000, 33'h0);
    for (int r = 0; r < 4; r++)
      run_one(r);
    stop_test();
  end
endmodule
`default_nettype wire
